// file: common/rps_defines.svh
// Summary of operation
// - Power-on sense low drives reset low
// - Reset stays low until firmware release
// - Reset asserts 5 us after other causes
// - Reset held 2 ms after release
// - Firmware bit drives reset output directly
// - Warning low 4 us: park, then reset
// - Stay in reset while warning low, except in the stretch
// - Warning good after 625 ns high
// - Power on/off high when powered up, low in standby
// - Memory init and test, record result
// - Test failure halts, init-done pulses twice
// - Address select sampled at power-up
// - Open-drain 400 kHz host slave port
`ifndef RPS_DEFINES_SVH
`define RPS_DEFINES_SVH
// Clock period and documented times
`define RPS_CLK_PERIOD_PS   4000
`define RPS_PARK_DELAY_NS   5000
`define RPS_GLITCH_NS       4000
`define RPS_GOOD_QUAL_PS    625000
`define RPS_STRETCH_MS      2
// Derived cycle counts, least times rounded up
`define RPS_PARK_CYC   ((`RPS_PARK_DELAY_NS * 1000 + `RPS_CLK_PERIOD_PS - 1) / `RPS_CLK_PERIOD_PS)
`define RPS_GLITCH_CYC ((`RPS_GLITCH_NS * 1000 + `RPS_CLK_PERIOD_PS - 1) / `RPS_CLK_PERIOD_PS)
`define RPS_GOOD_CYC   ((`RPS_GOOD_QUAL_PS + `RPS_CLK_PERIOD_PS - 1) / `RPS_CLK_PERIOD_PS)
`define RPS_STRETCH_CYC ((`RPS_STRETCH_MS * 1000000000 + `RPS_CLK_PERIOD_PS - 1) / `RPS_CLK_PERIOD_PS)
// Counter widths
`define RPS_TMR_W      20
`define RPS_QUAL_W     11
// Host port slave addresses, 7-bit form
`define RPS_ADDR_LOW   7'h1A
`define RPS_ADDR_HIGH  7'h1D
// Memory self-test
`define RPS_MEM_DEPTH  16
`define RPS_MEM_AW     4
`define RPS_MEM_LAST   4'hF
`define RPS_MEM_SEED   8'hA5
`define RPS_INIT_PULSE 8'h10
`endif

// file: common/rps_pkg.sv
package rps_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_POR, ST_HOLD, ST_STRETCH, ST_RUN, ST_PARK, ST_DOWN
  } rps_seq_e;
  // Memory test phases
  typedef enum logic [2:0] {
    MT_IDLE, MT_WRITE, MT_READ, MT_PASS, MT_FAIL1, MT_GAP, MT_FAIL2, MT_HALT
  } rps_mt_e;
  // Host port slave phases
  typedef enum logic [2:0] {
    HS_IDLE, HS_ADDR, HS_ACK_A, HS_WRITE, HS_ACK_W, HS_READ, HS_ACK_R
  } rps_hs_e;
  // Received host byte
  typedef struct packed {
    logic       valid;
    logic       first;
    logic [7:0] data;
  } rps_rx_s;
  // Memory self-test status
  typedef struct packed {
    logic done;
    logic pass;
    logic fail;
  } rps_mem_s;
endpackage : rps_pkg

// file: tb/reset_power_sequencing_tb_top.sv
`timescale 1ns/100ps
module reset_power_sequencing_tb_top
  import rps_pkg::*;
;
  localparam logic [19:0] STRETCH = 20'h000C8; // Short stretch keeps the run brief
  logic       clk, srst, fw_rel, fw_frc, int_rst, stby, fault, sel, ack, last_rst, last_ini;
  logic       ext_n, pwr, park, ini, scl_o, scl_oe_n, sda_o, sda_oe_n, rdq;
  logic [7:0] tx, d, q;
  logic [6:0] own, a;
  wire        sense, warn, m_scl, m_sda;
  wire        scl_bus = m_scl & (scl_oe_n | scl_o); // Pull-up wired-and
  wire        sda_bus = m_sda & (sda_oe_n | sda_o);
  rps_mem_s   mem;
  rps_rx_s    rx;
  logic       exp_rst[$]; // Expected reset levels in order
  logic [7:0] exp_rx[$];  // Expected received bytes
  int         miscompares, n_checks, n_init, n0, n_rd;
  rps_sequencer #(.STRETCH_CYC(STRETCH)) uut (.CLOCK_IN(clk), .SRST_IN(srst), .POWER_ON_SENSE_IN(sense),
    .SUPPLY_OK_WARN_IN(warn), .FW_RESET_RELEASE_IN(fw_rel), .FW_RESET_FORCE_IN(fw_frc),
    .INTERNAL_RESET_IN(int_rst), .STANDBY_IN(stby), .MEM_FAULT_INJECT_IN(fault), .HOST_TX_DATA_IN(tx),
    .ADDR_SEL_IN(sel), .HOST_PORT_SCL_IN(scl_bus), .HOST_PORT_SDA_IN(sda_bus), .EXT_RESET_N_OUT(ext_n),
    .POWER_ON_OFF_OUT(pwr), .PARK_REQ_OUT(park), .INIT_DONE_OUT(ini), .MEM_STATUS_OUT(mem),
    .HOST_PORT_SCL_OUT(scl_o), .HOST_PORT_SCL_OE_N_OUT(scl_oe_n), .HOST_PORT_SDA_OUT(sda_o),
    .HOST_PORT_SDA_OE_N_OUT(sda_oe_n), .HOST_RX_OUT(rx), .HOST_RD_REQ_OUT(rdq));
  rps_supply_host_model pm (.clk(clk), .sda_bus(sda_bus), .sense(sense), .warn(warn), .m_scl(m_scl), .m_sda(m_sda));
  task automatic chk_lvl(input logic g, input logic e);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: level %b expected %b", $time, g, e);
    end
  endtask : chk_lvl
  task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: value %h expected %h", $time, g, e);
    end
  endtask : chk_val
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic test_done();
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  // Firmware release pulse, then room for stretch and memory test
  task automatic release_fw();
    exp_rst.push_back(1'h1);
    fw_rel <= 1'h1;
    tick(1);
    fw_rel <= 1'h0;
    tick(STRETCH + 200);
  endtask : release_fw
  // Clock
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Watcher: every reset edge and received byte takes the oldest note
  always @(posedge clk)
  begin
    if (!srst && ext_n !== last_rst)
      chk_lvl(ext_n, exp_rst.size() ? exp_rst.pop_front() : last_rst);
    if (rx.valid === 1'h1)
    begin
      chk_val(rx.data, exp_rx.size() ? exp_rx.pop_front() : ~rx.data);
      chk_lvl(rx.first, 1'h1);
    end
    if (rdq === 1'h1)
      n_rd++;
    if (ini === 1'h1 && last_ini !== 1'h1)
      n_init++;
    last_rst = ext_n;
    last_ini = ini;
  end
  // Watchdog
  initial
  begin
    #250000;
    miscompares++;
    test_done();
  end
  // Main sequence
  initial
  begin
    srst    <= 1'h1;
    fw_rel  <= 1'h0;
    fw_frc  <= 1'h0;
    int_rst <= 1'h0;
    stby    <= 1'h0;
    fault   <= 1'h0;
    {last_rst, last_ini, miscompares, n_checks, n_init, n_rd} = '0;
    void'($urandom(84));
    sel <= 1'($urandom);
    tx  <= 8'($urandom);
    tick(6);
    srst <= 1'h0;
    pm.supply(1'h1, 1'h1);
    tick(300);
    chk_lvl(ext_n, 1'h0);
    own = sel ? 7'h1D : 7'h1A;
    sel <= ~sel;
    release_fw();
    chk_lvl(pwr, 1'h1);
    chk_val(8'(mem), 8'h06);
    // Own address acked, the other strap's address ignored, then a read back
    for (int i = 0; i < 3; i++)
    begin
      a = (i == 1) ? own ^ 7'h07 : own;
      d = 8'($urandom);
      tx <= 8'($urandom);
      tick(1);
      if (i == 0) exp_rx.push_back(d);
      pm.xfer(a, i == 2, d, q, ack);
      chk_lvl(ack, i == 1);
    end
    chk_val(q, tx);
    chk_val(8'(n_rd), 8'h01);
    // Standby follows the pin both ways, random order
    d = 8'($urandom);
    for (int i = 0; i < 4; i++)
    begin
      stby <= d[i/2] ^ i[0];
      tick(3);
      chk_lvl(pwr, ~(d[i/2] ^ i[0]));
    end
    stby <= 1'h0;
    // Short warning dip, then a real loss
    pm.supply(1'h1, 1'h0);
    tick(500);
    pm.supply(1'h1, 1'h1);
    tick(1500);
    exp_rst.push_back(1'h0);
    pm.supply(1'h1, 1'h0);
    tick(1100);
    chk_lvl(park & ext_n, 1'h1);
    tick(1900);
    chk_lvl(ext_n, 1'h0);
    pm.supply(1'h1, 1'h1);
    tick(300);
    release_fw();
    exp_rst.push_back(1'h0);
    fw_frc <= 1'h1;
    tick(10);
    exp_rst.push_back(1'h1);
    fw_frc <= 1'h0;
    tick(10);
    // Internal reset, then a failing memory test
    exp_rst.push_back(1'h0);
    int_rst <= 1'h1;
    tick(1);
    int_rst <= 1'h0;
    fault <= 1'h1;
    tick(1000);
    chk_lvl(ext_n, 1'h1);
    tick(400);
    n0 = n_init;
    release_fw();
    chk_val(8'(n_init - n0), 8'h02);
    chk_val(8'(mem), 8'h05);
    exp_rst.push_back(1'h0);
    pm.supply(1'h0, 1'h1);
    tick(5);
    chk_lvl(ext_n, 1'h0);
    pm.supply(1'h1, 1'h1);
    tick(300);
    chk_val(8'(exp_rst.size() + exp_rx.size()), 8'h00);
    test_done();
  end
endmodule : reset_power_sequencing_tb_top

// file: tb/rps_seq_props.sv
`timescale 1ns/100ps
`include "rps_defines.svh"
module rps_seq_props
  import rps_pkg::*;
#(
  parameter logic [`RPS_TMR_W-1:0] STRETCH_CYC = `RPS_TMR_W'(`RPS_STRETCH_CYC)
)
(
  // Clock and reset
  input wire logic     CLOCK_IN,
  input wire logic     SRST_IN,
  // Watched inputs
  input wire logic     POWER_ON_SENSE_IN,
  input wire logic     SUPPLY_OK_WARN_IN,
  input wire logic     FW_RESET_RELEASE_IN,
  input wire logic     FW_RESET_FORCE_IN,
  input wire logic     INTERNAL_RESET_IN,
  input wire logic     STANDBY_IN,
  input wire logic     HOST_PORT_SCL_IN,
  // Watched outputs
  input wire logic     EXT_RESET_N_OUT,
  input wire logic     POWER_ON_OFF_OUT,
  input wire logic     PARK_REQ_OUT,
  input wire logic     INIT_DONE_OUT,
  input wire rps_mem_s MEM_STATUS_OUT,
  input wire logic     HOST_PORT_SDA_OE_N_OUT,
  input wire rps_rx_s  HOST_RX_OUT
);
  logic        rel_q; // Release seen while reset low
  logic        frc_q; // Reset low came from the force bit
  logic [19:0] cnt_q; // Cycles since last release pulse
  logic [19:0] wh_q;  // Warning high run length
  logic [10:0] wl_q;  // Warning low run length
  logic [10:0] pk_q;  // Park request length
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);
  // Cause bookkeeping, cleared once reset is high again
  always_ff @(posedge CLOCK_IN)
  begin
    rel_q <= !SRST_IN && !EXT_RESET_N_OUT && (rel_q || FW_RESET_RELEASE_IN);
    frc_q <= !SRST_IN && (FW_RESET_FORCE_IN || (frc_q && !EXT_RESET_N_OUT));
  end
  // Run lengths; cnt_q, wh_q and wl_q saturate so long runs never wrap, pk_q just counts up
  always_ff @(posedge CLOCK_IN)
  begin
    cnt_q <= FW_RESET_RELEASE_IN ? 20'h00000 : cnt_q + {19'h0, ~&cnt_q};
    wh_q  <= !SUPPLY_OK_WARN_IN ? 20'h00000 : wh_q + {19'h0, ~&wh_q};
    wl_q  <= SUPPLY_OK_WARN_IN ? 11'h000 : wl_q + {10'h0, ~&wl_q};
    pk_q  <= !PARK_REQ_OUT ? 11'h000 : pk_q + 11'h001;
  end
  chk_sense_hold: assert property ((!POWER_ON_SENSE_IN) [*5] |-> !EXT_RESET_N_OUT)
    else $error("reset high while sense low");
  chk_release_first: assert property ($rose(EXT_RESET_N_OUT) && !frc_q |-> rel_q)
    else $error("reset rose without release");
  chk_stretch_min: assert property ($rose(EXT_RESET_N_OUT) && !frc_q |-> cnt_q >= STRETCH_CYC)
    else $error("reset stretch too short");
  chk_park_length: assert property ($fell(PARK_REQ_OUT) |-> pk_q == 11'h4E2 ##[0:1] !EXT_RESET_N_OUT)
    else $error("park delay length wrong");
  chk_park_cause: assert property ($rose(PARK_REQ_OUT) |-> wl_q >= 11'h3E8 || $past(INTERNAL_RESET_IN)
    || $past(INTERNAL_RESET_IN, 2)) else $error("park without long warning");
  chk_warn_hold: assert property (!EXT_RESET_N_OUT && !SUPPLY_OK_WARN_IN |=> !EXT_RESET_N_OUT)
    else $error("reset left while warning low");
  chk_good_qual: assert property ($rose(EXT_RESET_N_OUT) && !frc_q |-> {1'b0, wh_q} >= {1'b0, cnt_q} + 21'h0009D)
    else $error("warning not qualified before release");
  chk_force_reset: assert property (FW_RESET_FORCE_IN ##1 FW_RESET_FORCE_IN |-> !EXT_RESET_N_OUT)
    else $error("force bit ignored");
  chk_standby_off: assert property (STANDBY_IN ##1 STANDBY_IN |-> !POWER_ON_OFF_OUT)
    else $error("power on during standby");
  chk_power_on: assert property ((POWER_ON_SENSE_IN && !STANDBY_IN) [*6] |-> POWER_ON_OFF_OUT)
    else $error("power off while powered");
  chk_mem_pass: assert property ($rose(MEM_STATUS_OUT.pass) |-> ##[0:2] INIT_DONE_OUT && !MEM_STATUS_OUT.fail)
    else $error("pass without init done");
  chk_fail_gap: assert property ($fell(INIT_DONE_OUT) && MEM_STATUS_OUT.fail |-> (!INIT_DONE_OUT) [*8])
    else $error("fail pulse gap too short");
  chk_sda_change: assert property ($changed(HOST_PORT_SDA_OE_N_OUT) |-> !HOST_PORT_SCL_IN)
    else $error("data line moved while clock high");
  // Main scenarios reached
  cov_park: cover property ($fell(PARK_REQ_OUT));
  cov_fail: cover property ($rose(MEM_STATUS_OUT.fail));
  cov_rx: cover property (HOST_RX_OUT.valid);
  cov_ack: cover property ($fell(HOST_PORT_SDA_OE_N_OUT));
endmodule : rps_seq_props

bind rps_sequencer rps_seq_props #(.STRETCH_CYC(STRETCH_CYC)) u_props (
  .CLOCK_IN(CLOCK_IN), .SRST_IN(SRST_IN), .POWER_ON_SENSE_IN(POWER_ON_SENSE_IN),
  .SUPPLY_OK_WARN_IN(SUPPLY_OK_WARN_IN), .FW_RESET_RELEASE_IN(FW_RESET_RELEASE_IN),
  .FW_RESET_FORCE_IN(FW_RESET_FORCE_IN), .INTERNAL_RESET_IN(INTERNAL_RESET_IN), .STANDBY_IN(STANDBY_IN),
  .HOST_PORT_SCL_IN(HOST_PORT_SCL_IN), .EXT_RESET_N_OUT(EXT_RESET_N_OUT), .POWER_ON_OFF_OUT(POWER_ON_OFF_OUT),
  .PARK_REQ_OUT(PARK_REQ_OUT), .INIT_DONE_OUT(INIT_DONE_OUT), .MEM_STATUS_OUT(MEM_STATUS_OUT),
  .HOST_PORT_SDA_OE_N_OUT(HOST_PORT_SDA_OE_N_OUT), .HOST_RX_OUT(HOST_RX_OUT));

// file: tb/rps_supply_host_model.sv
`timescale 1ns/100ps
module rps_supply_host_model
(
  // Clock and resolved data line
  input  wire logic clk,
  input  wire logic sda_bus,
  // Supply monitor levels
  output logic      sense,
  output logic      warn,
  // Host lines, high means released to pull-up
  output logic      m_scl,
  output logic      m_sda
);
  localparam int QTR = 157; // Quarter bit, keeps the clock under 400 kHz
  // Supplies off, bus idle
  initial
  begin
    sense = 1'h0;
    warn  = 1'h0;
    m_scl = 1'h1;
    m_sda = 1'h1;
  end
  // Supply levels; warning only ever lowered with sense high
  task automatic supply(input logic s, input logic w);
    @(posedge clk);
    sense <= s;
    warn  <= w;
  endtask : supply
  task automatic qw();
    repeat (QTR) @(posedge clk);
  endtask : qw
  // One bit, data set while clock low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    m_sda <= b;
    qw();
    m_scl <= 1'h1;
    qw();
    r = sda_bus;
    qw();
    m_scl <= 1'h0;
    qw();
  endtask : bit_io
  // One frame, MSB first; data only after an address ack
  // A read sends ones so the slave can pull low, then a nack ends it
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] d, output logic [7:0] q,
                      output logic ack);
    logic [7:0] v;
    logic       r;
    v = {a, rd};
    q = 8'h00;
    m_sda <= 1'h0;
    qw();
    m_scl <= 1'h0;
    qw();
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'h1, ack);
    if (ack === 1'h0)
    begin
      for (int i = 7; i >= 0; i--) bit_io(rd | d[i], q[i]);
      bit_io(1'h1, r);
    end
    m_sda <= 1'h0;
    qw();
    m_scl <= 1'h1;
    qw();
    m_sda <= 1'h1;
    qw();
  endtask : xfer
endmodule : rps_supply_host_model

// file: verilog/rps_host_slave.sv
`timescale 1ns/100ps
`include "rps_defines.svh"
module rps_host_slave
  import rps_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enable,
  // Bus lines, sampled
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       addr_sel,
  // Read data source
  input  wire logic [7:0] tx_data,
  // Results
  output logic            sda_oe_n,
  output rps_rx_s         rx,
  output logic            rd_req
);
  rps_hs_e    st_q;      // Slave phase
  logic       scl_q;     // Previous line levels
  logic       sda_q;
  logic [2:0] cnt_q;     // Bit counter
  logic       got_q;     // Eight bits seen
  logic [7:0] sh_q;      // Receive shift
  logic [7:0] tx_q;      // Transmit shift
  logic       rw_q;      // Read direction
  logic       nack_q;    // Master declined more data
  logic       first_q;   // Next byte is first after address
  logic [6:0] addr;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;

  // Address select picks one of two addresses
  assign addr  = addr_sel ? `RPS_ADDR_HIGH : `RPS_ADDR_LOW;
  assign rise  = scl_in & ~scl_q;
  assign fall  = ~scl_in & scl_q;
  assign start = scl_in & scl_q & sda_q & ~sda_in;
  assign stop  = scl_in & scl_q & ~sda_q & sda_in;

  // Line history for edge detection
  always_ff @(posedge clk)
  begin
    scl_q <= rst ? 1'b1 : scl_in;
    sda_q <= rst ? 1'b1 : sda_in;
  end

  // Bit shifting and counting on clock rise
  always_ff @(posedge clk)
  begin
    if (rst || start)
    begin
      cnt_q <= 3'h0;
      got_q <= 1'b0;
      sh_q  <= 8'h00;
    end
    else if (rise && (st_q == HS_ADDR || st_q == HS_WRITE || st_q == HS_READ))
    begin
      sh_q  <= {sh_q[6:0], sda_in};
      cnt_q <= cnt_q + 3'h1;
      got_q <= (cnt_q == 3'h7);
    end
    else if (fall)
      got_q <= 1'b0;
  end

  // Protocol phases; open-drain so we only ever pull low
  always_ff @(posedge clk)
  begin
    rx.valid <= 1'b0;
    rd_req   <= 1'b0;
    if (rst || !enable)
    begin
      st_q     <= HS_IDLE;
      sda_oe_n <= 1'b1;
      rw_q     <= 1'b0;
      nack_q   <= 1'b0;
      first_q  <= 1'b0;
      tx_q     <= 8'h00;
      rx.first <= 1'b0;
      rx.data  <= 8'h00;
    end
    else if (start)
    begin
      st_q     <= HS_ADDR;
      sda_oe_n <= 1'b1;
    end
    else if (stop)
    begin
      st_q     <= HS_IDLE;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      unique case (st_q)
        HS_IDLE: ;
        HS_ADDR:
          if (fall && got_q)
          begin
            // Foreign address: stay off the bus until next start
            if (sh_q[7:1] == addr)
            begin
              sda_oe_n <= 1'b0;
              rw_q     <= sh_q[0];
              st_q     <= HS_ACK_A;
            end
            else
              st_q <= HS_IDLE;
          end
        HS_ACK_A, HS_ACK_R:
          if (rise)
            nack_q <= (st_q == HS_ACK_R) & sda_in;
          else if (fall)
          begin
            if (rw_q && !nack_q)
            begin
              sda_oe_n <= tx_data[7];
              tx_q     <= {tx_data[6:0], 1'b1};
              rd_req   <= 1'b1;
              st_q     <= HS_READ;
            end
            else
            begin
              sda_oe_n <= 1'b1;
              first_q  <= 1'b1;
              st_q     <= rw_q ? HS_IDLE : HS_WRITE;
            end
            nack_q <= 1'b0;
          end
        HS_WRITE:
          if (fall && got_q)
          begin
            sda_oe_n <= 1'b0;
            rx.valid <= 1'b1;
            rx.first <= first_q;
            rx.data  <= sh_q;
            first_q  <= 1'b0;
            st_q     <= HS_ACK_W;
          end
        HS_ACK_W:
          if (fall)
          begin
            sda_oe_n <= 1'b1;
            st_q     <= HS_WRITE;
          end
        HS_READ:
          if (fall)
          begin
            if (got_q)
            begin
              sda_oe_n <= 1'b1;
              st_q     <= HS_ACK_R;
            end
            else
            begin
              sda_oe_n <= tx_q[7];
              tx_q     <= {tx_q[6:0], 1'b1};
            end
          end
        // Unused code: back to idle with the data line left as it is, wait for a start
        default:
          st_q <= HS_IDLE;
      endcase
    end
  end
endmodule : rps_host_slave

// file: verilog/rps_sequencer.sv
`timescale 1ns/100ps
`include "rps_defines.svh"
module rps_sequencer
  import rps_pkg::*;
#(
  parameter logic [`RPS_TMR_W-1:0] STRETCH_CYC = `RPS_TMR_W'(`RPS_STRETCH_CYC)
)
(
  // Clock and reset
  input  wire logic       CLOCK_IN,
  input  wire logic       SRST_IN,
  // Supply monitor
  input  wire logic       POWER_ON_SENSE_IN,
  input  wire logic       SUPPLY_OK_WARN_IN,
  // Firmware controls
  input  wire logic       FW_RESET_RELEASE_IN,
  input  wire logic       FW_RESET_FORCE_IN,
  input  wire logic       INTERNAL_RESET_IN,
  input  wire logic       STANDBY_IN,
  input  wire logic       MEM_FAULT_INJECT_IN,
  input  wire logic [7:0] HOST_TX_DATA_IN,
  // Straps and host port lines
  input  wire logic       ADDR_SEL_IN,
  input  wire logic       HOST_PORT_SCL_IN,
  input  wire logic       HOST_PORT_SDA_IN,
  // Reset and power outputs
  output logic            EXT_RESET_N_OUT,
  output logic            POWER_ON_OFF_OUT,
  output logic            PARK_REQ_OUT,
  output logic            INIT_DONE_OUT,
  output rps_mem_s        MEM_STATUS_OUT,
  // Host port outputs
  output logic            HOST_PORT_SCL_OUT,
  output logic            HOST_PORT_SCL_OE_N_OUT,
  output logic            HOST_PORT_SDA_OUT,
  output logic            HOST_PORT_SDA_OE_N_OUT,
  output rps_rx_s         HOST_RX_OUT,
  output logic            HOST_RD_REQ_OUT
);
  logic [1:0]            sense_sy_q;  // Sense synchroniser
  logic [1:0]            warn_sy_q;   // Warning synchroniser
  logic [`RPS_QUAL_W-1:0] low_cnt_q;  // Warning low duration
  logic [`RPS_QUAL_W-1:0] high_cnt_q; // Warning high duration
  logic                  lost_q;      // Qualified supply loss
  logic                  good_q;      // Qualified supply good
  rps_seq_e              st_q;        // Sequencer state
  logic [`RPS_TMR_W-1:0] tmr_q;       // Park delay and stretch timer
  logic                  sel_q;       // Captured address select
  logic                  sense_d1_q;  // Previous synced sense
  rps_mt_e               mt_q;        // Memory test phase
  logic [`RPS_MEM_AW-1:0] ma_q;       // Memory test address
  logic [7:0]            mem_q [`RPS_MEM_DEPTH]; // Internal memory under test
  logic [7:0]            pw_q;        // INIT_DONE pulse width timer
  logic [7:0]            pat;         // Expected pattern at ma_q
  logic                  sense;

  assign sense = sense_sy_q[1];
  assign pat   = `RPS_MEM_SEED ^ {4'h0, ma_q};

  // Two-flop synchronisers; only stage two is looked at
  always_ff @(posedge CLOCK_IN)
  begin
    sense_sy_q <= SRST_IN ? 2'h0 : {sense_sy_q[0], POWER_ON_SENSE_IN};
    warn_sy_q  <= SRST_IN ? 2'h0 : {warn_sy_q[0], SUPPLY_OK_WARN_IN};
  end

  // Glitch filter on loss and qualification on return
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      low_cnt_q  <= '0;
      high_cnt_q <= '0;
      lost_q     <= 1'b0;
      good_q     <= 1'b0;
    end
    else if (warn_sy_q[1])
    begin
      low_cnt_q <= '0;
      lost_q    <= 1'b0;
      if (high_cnt_q != `RPS_QUAL_W'(`RPS_GOOD_CYC))
        high_cnt_q <= high_cnt_q + `RPS_QUAL_W'(1);
      good_q <= (high_cnt_q >= `RPS_QUAL_W'(`RPS_GOOD_CYC - 1));
    end
    else
    begin
      // Short lows never reach the count, so they are dropped
      high_cnt_q <= '0;
      good_q     <= 1'b0;
      if (low_cnt_q != `RPS_QUAL_W'(`RPS_GLITCH_CYC))
        low_cnt_q <= low_cnt_q + `RPS_QUAL_W'(1);
      lost_q <= (low_cnt_q >= `RPS_QUAL_W'(`RPS_GLITCH_CYC - 1));
    end
  end

  // Reset sequencer; sense loss overrides everything else
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN || !sense)
    begin
      st_q  <= ST_POR;
      tmr_q <= '0;
    end
    else
    begin
      unique case (st_q)
        ST_POR:
          st_q <= ST_HOLD;
        ST_HOLD:
          // Held until firmware release and supply is good
          if (FW_RESET_RELEASE_IN && good_q)
          begin
            st_q  <= ST_STRETCH;
            tmr_q <= '0;
          end
        ST_STRETCH:
          if (tmr_q == STRETCH_CYC - `RPS_TMR_W'(1))
            st_q <= ST_RUN;
          else
            tmr_q <= tmr_q + `RPS_TMR_W'(1);
        ST_RUN:
          if (lost_q || INTERNAL_RESET_IN)
          begin
            st_q  <= ST_PARK;
            tmr_q <= '0;
          end
        ST_PARK:
          // Mirrors parked during the delay, then reset asserts
          if (tmr_q == `RPS_TMR_W'(`RPS_PARK_CYC - 1))
            st_q <= ST_DOWN;
          else
            tmr_q <= tmr_q + `RPS_TMR_W'(1);
        ST_DOWN:
          if (good_q)
            st_q <= ST_HOLD;
        // Unused codes fall back to the safe power-on state
        default:
          st_q <= ST_POR;
      endcase
    end
  end

  // Outputs of the sequencer, registered
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      EXT_RESET_N_OUT  <= 1'b0;
      POWER_ON_OFF_OUT <= 1'b0;
      PARK_REQ_OUT     <= 1'b0;
    end
    else
    begin
      // Firmware force drives the pin regardless of sequencing
      EXT_RESET_N_OUT  <= sense && !FW_RESET_FORCE_IN &&
                          (st_q == ST_RUN || st_q == ST_PARK);
      POWER_ON_OFF_OUT <= sense && !STANDBY_IN;
      PARK_REQ_OUT     <= sense && (st_q == ST_PARK);
    end
  end

  // Address select caught on the rising edge of power-on sense
  always_ff @(posedge CLOCK_IN)
  begin
    sense_d1_q <= SRST_IN ? 1'b0 : sense;
    if (SRST_IN)
      sel_q <= 1'b0;
    else if (sense && !sense_d1_q)
      sel_q <= ADDR_SEL_IN;
  end

  // Memory contents; fault inject corrupts bit zero of writes
  always_ff @(posedge CLOCK_IN)
  begin
    if (mt_q == MT_WRITE)
      mem_q[ma_q] <= pat ^ {7'h00, MEM_FAULT_INJECT_IN};
  end

  // Memory init and test, run before any code would be copied
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN || st_q != ST_RUN)
    begin
      mt_q           <= MT_IDLE;
      ma_q           <= '0;
      pw_q           <= 8'h00;
      MEM_STATUS_OUT <= '0;
      INIT_DONE_OUT  <= 1'b0;
    end
    else
    begin
      unique case (mt_q)
        MT_IDLE:
          mt_q <= MT_WRITE;
        MT_WRITE:
          begin
            ma_q <= ma_q + `RPS_MEM_AW'(1);
            if (ma_q == `RPS_MEM_LAST)
              mt_q <= MT_READ;
          end
        MT_READ:
          if (mem_q[ma_q] != pat)
          begin
            // Any mismatch halts; result kept in status
            MEM_STATUS_OUT <= '{done: 1'b1, pass: 1'b0, fail: 1'b1};
            INIT_DONE_OUT  <= 1'b1;
            mt_q           <= MT_FAIL1;
          end
          else if (ma_q == `RPS_MEM_LAST)
          begin
            MEM_STATUS_OUT <= '{done: 1'b1, pass: 1'b1, fail: 1'b0};
            INIT_DONE_OUT  <= 1'b1;
            mt_q           <= MT_PASS;
          end
          else
            ma_q <= ma_q + `RPS_MEM_AW'(1);
        MT_PASS: ;
        MT_FAIL1, MT_GAP, MT_FAIL2:
          // Two pulses of equal width mark the failure
          if (pw_q == `RPS_INIT_PULSE - 8'h01)
          begin
            pw_q          <= 8'h00;
            INIT_DONE_OUT <= (mt_q == MT_GAP);
            mt_q          <= (mt_q == MT_FAIL1) ? MT_GAP :
                             (mt_q == MT_GAP) ? MT_FAIL2 : MT_HALT;
          end
          else
            pw_q <= pw_q + 8'h01;
        MT_HALT: ;
      endcase
    end
  end

  // Host port: clock line never stretched, data pulled low only
  always_ff @(posedge CLOCK_IN)
  begin
    HOST_PORT_SCL_OUT      <= 1'b0;
    HOST_PORT_SCL_OE_N_OUT <= 1'b1;
    HOST_PORT_SDA_OUT      <= 1'b0;
  end

  // Slave answers only while the controller runs
  rps_host_slave u_slave (
    .clk      (CLOCK_IN),
    .rst      (SRST_IN),
    .enable   (st_q == ST_RUN),
    .scl_in   (HOST_PORT_SCL_IN),
    .sda_in   (HOST_PORT_SDA_IN),
    .addr_sel (sel_q),
    .tx_data  (HOST_TX_DATA_IN),
    .sda_oe_n (HOST_PORT_SDA_OE_N_OUT),
    .rx       (HOST_RX_OUT),
    .rd_req   (HOST_RD_REQ_OUT)
  );
endmodule : rps_sequencer
